//--- shared/timing_ref_pkg.sv
// Constants for timing reference insertion and recovery
package timing_ref_pkg;
    localparam int NUM_LINKS = 8;
    localparam int LINK_IDX_W = 3;
    localparam int CLK_PERIOD_PS = 25000;
    localparam int BITS_PER_BYTE = 8;
    localparam int BIT_PERIOD_PS = CLK_PERIOD_PS / BITS_PER_BYTE;
    localparam int PULSE_BITS = 16;
    localparam int PULSE_CYCLES = PULSE_BITS / BITS_PER_BYTE;
    localparam logic [1:0] PULSE_CNT_LOAD = 2'(PULSE_CYCLES);
    localparam logic [7:0] MARK_RESET = 8'h00;
    localparam logic [2:0] LINK_SEL_RESET = 3'h0;
    localparam int SYNC_STAGES = 3;
endpackage

//--- rtl/pin_sync.sv
// Three-stage pin synchroniser with agreement filter and rising-edge pulse
`timescale 1ns/1ps
module pin_sync #(
    parameter int W = 1
) (
    // Clock and reset
    input wire logic CLK,
    input wire logic NRST,
    // Asynchronous pin
    input wire logic [W-1:0] PIN,
    // Filtered level and bitwise rising-edge pulses
    output logic [W-1:0] LEVEL,
    output logic [W-1:0] RISE
);
    typedef struct packed {
        logic [W-1:0] s1;
        logic [W-1:0] s2;
        logic [W-1:0] s3;
        logic [W-1:0] level;
        logic [W-1:0] rise;
    } sync_s;

    sync_s cur_q;
    sync_s nxt_d;

    always_comb begin
        nxt_d = cur_q;
        nxt_d.s1 = PIN;
        nxt_d.s2 = cur_q.s1;
        nxt_d.s3 = cur_q.s2;
        nxt_d.rise = '0;
        // A change counts only once stages two and three agree
        for (int i = 0; i < W; i++) begin
            if (cur_q.s2[i] == cur_q.s3[i]) begin
                nxt_d.level[i] = cur_q.s3[i];
                nxt_d.rise[i] = cur_q.s3[i] & ~cur_q.level[i];
            end
        end
    end

    always_ff @(posedge CLK or negedge NRST) begin
        if (!NRST) begin
            cur_q <= '0;
        end else begin
            cur_q <= nxt_d;
        end
    end

    assign LEVEL = cur_q.level;
    assign RISE = cur_q.rise;
endmodule // pin_sync

//--- rtl/timing_ref_insert_recover.sv
// Timing reference insertion into transmit cells and recovery from one receive link
//
// Summary of operation
// - Serial bit rate is eight times the reference clock rate: one clock per serial byte.
// - One reference clock times both transmit synthesis and receive recovery.
// - Link data is NRZ both ways; byte lanes here pass NRZ bytes unchanged.
// - Timing reference edges are carried to the far end on every transmit link.
// - A rising reference edge is marked in the next cell to start after the cycle it is detected in.
// - Recovered reference comes from markers on exactly one receive link.
// - Recovered output rises on a serial byte boundary, i.e. a clock edge.
// - Each recovered pulse stays high sixteen bit periods, two reference clocks.
`timescale 1ns/1ps
module timing_ref_insert_recover (
    // Reference clock (one period per serial byte) and reset
    input wire logic CLK,
    input wire logic NRST,
    // Transmit timing reference pin
    input wire logic TX_TIMING_REF_IN,
    // Transmit cell framing, one bit per link, from the cell transmitter
    input wire logic [7:0] TX_CELL_START,
    output logic [7:0] TX_CELL_MARK,
    // Transmit NRZ byte lanes, one byte per clock per link
    input wire logic [63:0] TX_LINK_BYTES,
    output logic [63:0] SERIAL_TX_PAIR,
    // Receive NRZ byte lanes and cell marker decode, one bit per link
    input wire logic [63:0] SERIAL_RX_PAIR,
    output logic [63:0] RX_LINK_BYTES,
    input wire logic [7:0] RX_CELL_MARK,
    // Source link for the recovered reference, static strap
    input wire logic [2:0] RX_LINK_SELECT,
    // Recovered timing reference
    output logic RX_TIMING_REF_OUT
);
    typedef struct packed {
        logic [7:0] pending;
        logic [7:0] mark;
        logic [63:0] tx_bytes;
        logic [63:0] rx_bytes;
        logic [1:0] pulse_cnt;
        logic ref_out;
    } state_s;

    state_s cur_q;
    state_s nxt_d;
    logic ref_rise;
    logic [2:0] link_sel;

    // Reference edge detected only after three-stage synchronisation
    pin_sync #(.W(1)) u_ref_sync (
        .CLK(CLK),
        .NRST(NRST),
        .PIN(TX_TIMING_REF_IN),
        .LEVEL(),
        .RISE(ref_rise)
    );

    // Select strap crosses from the board, so it gets the same filter
    pin_sync #(.W(timing_ref_pkg::LINK_IDX_W)) u_sel_sync (
        .CLK(CLK),
        .NRST(NRST),
        .PIN(RX_LINK_SELECT),
        .LEVEL(link_sel),
        .RISE()
    );

    function automatic logic link_bit(input logic [7:0] v, input logic [2:0] idx);
        link_bit = v[idx];
    endfunction

    always_comb begin
        nxt_d = cur_q;
        // CLK is the reference clock: each edge is one serial byte boundary on every link
        nxt_d.tx_bytes = TX_LINK_BYTES;
        nxt_d.rx_bytes = SERIAL_RX_PAIR;
        for (int l = 0; l < timing_ref_pkg::NUM_LINKS; l++) begin
            // Cell start consumes the pending mark for this link
            if (TX_CELL_START[l]) begin
                nxt_d.mark[l] = cur_q.pending[l];
                nxt_d.pending[l] = 1'b0;
            end
            // Set wins over clear: an edge at cell start goes to the following cell
            if (ref_rise) begin
                nxt_d.pending[l] = 1'b1;
            end
        end
        // A second edge before a cell leaves merges with the first
        if (cur_q.pulse_cnt != 2'h0) begin
            nxt_d.pulse_cnt = cur_q.pulse_cnt - 2'h1;
        end
        // Only the selected link may start a pulse; retriggers during a pulse are
        // ignored since the reference runs below the cell rate
        if (cur_q.pulse_cnt == 2'h0 && link_bit(RX_CELL_MARK, link_sel)) begin
            nxt_d.pulse_cnt = timing_ref_pkg::PULSE_CNT_LOAD;
        end
        // Registered output rises on a clock edge, i.e. a byte boundary
        nxt_d.ref_out = (nxt_d.pulse_cnt != 2'h0);
    end

    always_ff @(posedge CLK or negedge NRST) begin
        if (!NRST) begin
            cur_q.pending <= timing_ref_pkg::MARK_RESET;
            cur_q.mark <= timing_ref_pkg::MARK_RESET;
            cur_q.tx_bytes <= 64'h0;
            cur_q.rx_bytes <= 64'h0;
            cur_q.pulse_cnt <= 2'h0;
            cur_q.ref_out <= 1'b0;
        end else begin
            cur_q <= nxt_d;
        end
    end

    assign TX_CELL_MARK = cur_q.mark;
    assign SERIAL_TX_PAIR = cur_q.tx_bytes;
    assign RX_LINK_BYTES = cur_q.rx_bytes;
    assign RX_TIMING_REF_OUT = cur_q.ref_out;
endmodule // timing_ref_insert_recover

//--- testbench/timing_ref_checker.sv
// Port assertions for the timing reference block
`timescale 1ns/1ps
module timing_ref_checker (
    // Watched ports, grouped by width to stay compact
    input wire logic CLK, NRST, TX_TIMING_REF_IN, RX_TIMING_REF_OUT,
    input wire logic [7:0] TX_CELL_START, TX_CELL_MARK, RX_CELL_MARK,
    input wire logic [63:0] TX_LINK_BYTES, SERIAL_TX_PAIR, SERIAL_RX_PAIR, RX_LINK_BYTES,
    input wire logic [2:0] RX_LINK_SELECT
);
    default clocking @(posedge CLK); endclocking
    default disable iff (!NRST);
    wire logic sm = RX_CELL_MARK[RX_LINK_SELECT];
    wire logic ro = RX_TIMING_REF_OUT;
    wire logic tr = TX_TIMING_REF_IN;
    // Lanes are only compared once the previous edge was out of reset
    a_tx_lane: assert property ($past(NRST) |-> SERIAL_TX_PAIR == $past(TX_LINK_BYTES))
        else $error("tx lane");
    a_rx_lane: assert property ($past(NRST) |-> RX_LINK_BYTES == $past(SERIAL_RX_PAIR))
        else $error("rx lane");
    a_pulse_width: assert property ($rose(ro) |-> ro ##1 ro ##1 !ro)
        else $error("pulse width");
    a_rise_cause: assert property ($rose(ro) |-> $past(sm))
        else $error("pulse cause");
    a_take_mark: assert property (sm && !ro |=> ro)
        else $error("mark missed");
    a_mark_cause: assert property (((TX_CELL_MARK ^ $past(TX_CELL_MARK)) & ~$past(TX_CELL_START)) == 8'h00)
        else $error("mark moved");
    // Filter counts an edge only after two low then two high samples; set wins one edge later
    a_mark_link: assert property (!tr [*2] ##1 tr [*2] ##4 TX_CELL_START[7] |=> TX_CELL_MARK[7])
        else $error("mark late");
    a_mark_all: assert property (!tr [*2] ##1 tr [*2] ##4 TX_CELL_START == 8'hFF |=> TX_CELL_MARK == 8'hFF)
        else $error("links unmarked");
    c_pulse: cover property ($rose(ro));
    c_mark: cover property ($rose(TX_CELL_MARK[0]));
    c_clear: cover property ($fell(TX_CELL_MARK[0]));
endmodule // timing_ref_checker
bind timing_ref_insert_recover timing_ref_checker u_chk (.*);

//--- testbench/timing_ref_peer.sv
// Far-end peer: receive bytes and cell markers
`timescale 1ns/1ps
module timing_ref_peer (
    // Marker request and receive lanes
    input wire logic clk,
    input wire logic go,
    input wire logic [2:0] lnk,
    output logic [7:0] mark,
    output logic [63:0] bytes_o
);
    initial {mark, bytes_o} = 72'h0;
    // Lanes change every cycle so a stale copy never matches
    always @(posedge clk) begin
        bytes_o <= bytes_o + 64'h1357_9BDF_2468_ACE1;
        mark <= go ? 8'h01 << lnk : 8'h00;
    end
endmodule // timing_ref_peer

//--- testbench/timing_ref_insert_recover_test.sv
// Bench for timing reference insert and recover
`timescale 1ns/1ps
`define CHK(a, b) begin num_checks++; if ((a) !== (b)) begin n_mismatch++; $display("BAD %0t %h %h", $time, a, b); end end
module timing_ref_insert_recover_test;
    logic CLK = 1'b0, NRST = 1'b0, pin = 1'b0, go = 1'b0, ro;
    logic [2:0] sel = 3'h0, lnk = 3'h0;
    logic [7:0] st = 8'h00, tm, rm;
    logic [63:0] rx, rx_prev, stx, rxo;
    int n_mismatch = 0, num_checks = 0;
    // Select, marker link, pulse expected
    logic [6:0] rows [10] = '{7'h01, 7'h13, 7'h25, 7'h37, 7'h49, 7'h5B, 7'h6D, 7'h7F, 7'h7C, 7'h0E};
    always #12.5 CLK = ~CLK;
    // Receive lanes as the design samples them, for the one-cycle delay check
    always @(posedge CLK) rx_prev <= rx;
    timing_ref_insert_recover u_timing_ref_insert_recover (.CLK(CLK), .NRST(NRST), .TX_TIMING_REF_IN(pin),
        .TX_CELL_START(st), .TX_CELL_MARK(tm), .TX_LINK_BYTES({8{sel, lnk, go, pin}}), .SERIAL_TX_PAIR(stx),
        .SERIAL_RX_PAIR(rx), .RX_LINK_BYTES(rxo), .RX_CELL_MARK(rm), .RX_LINK_SELECT(sel), .RX_TIMING_REF_OUT(ro));
    timing_ref_peer u_timing_ref_peer (.clk(CLK), .go(go), .lnk(lnk), .mark(rm), .bytes_o(rx));
    task automatic end_sim;
        $display("checks %0d mismatches %0d", num_checks, n_mismatch);
        if (n_mismatch == 0 && num_checks > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    initial begin
        #20000;
        n_mismatch++;
        end_sim();
    end
    initial begin
        repeat (12) @(posedge CLK);
        `CHK({tm, ro}, 9'h0)
        $display("reset test done");
        NRST <= 1'b1;
        foreach (rows[i]) begin
            @(posedge CLK) sel <= rows[i][6:4];
            lnk <= rows[i][3:1];
            // Select strap is filtered, so let it settle first
            repeat (6) @(posedge CLK);
            go <= 1'b1;
            @(posedge CLK) go <= 1'b0;
            repeat (2) @(negedge CLK);
            `CHK(ro, rows[i][0])
            @(negedge CLK) `CHK(ro, rows[i][0])
            @(negedge CLK) `CHK(ro, 1'b0)
            `CHK(stx, {8{sel, lnk, go, pin}})
            `CHK(rxo, rx_prev)
            $display("row %0d done", i);
        end
        // Back-to-back marks: the second lands inside the pulse and is ignored
        @(posedge CLK) go <= 1'b1;
        lnk <= 3'h0;
        repeat (2) @(posedge CLK);
        go <= 1'b0;
        @(negedge CLK) `CHK(ro, 1'b1)
        @(negedge CLK) `CHK(ro, 1'b1)
        @(negedge CLK) `CHK(ro, 1'b0)
        $display("retrigger test done");
        @(posedge CLK) pin <= 1'b1;
        repeat (4) @(posedge CLK);
        // Two cell starts; the filtered edge meets the first, so only the second is marked
        st <= 8'hFF;
        repeat (2) @(negedge CLK);
        `CHK(tm, 8'h00)
        @(posedge CLK) st <= 8'h00;
        @(negedge CLK) `CHK(tm, 8'hFF)
        @(posedge CLK) st <= 8'h81;
        pin <= 1'b0;
        @(posedge CLK) st <= 8'h00;
        @(negedge CLK) `CHK(tm, 8'h7E)
        $display("tx marker test done");
        // Reset in mid-run clears the held marks at once
        @(posedge CLK) NRST <= 1'b0;
        @(negedge CLK) `CHK({tm, ro}, 9'h000)
        @(posedge CLK) NRST <= 1'b1;
        $display("mid-run reset test done");
        end_sim();
    end
endmodule // timing_ref_insert_recover_test
